// ### src/rtf_pkg.sv
// Purpose: Constants, register map and threshold helpers for the
//          radio transmit/receive data buffer block.
// Assumes: Avalon-MM slave with 32-bit data, byte addresses.
// Notes:   Overview of operation follows.
//
// Overview of operation
// [RULE1] Two independent 64-byte buffers, receive and transmit.
// [RULE2] Host only pops receive, pushes transmit.
// [RULE3] Flag receive overflow and transmit underflow.
// [RULE4] Host must not overfill the transmit buffer.
// [RULE5] Host must not read an empty receive buffer.
// [RULE6] Header status shows receive or transmit fill.
// [RULE7] Separate read-only receive and transmit fill counts.
// [RULE8] Push during last-byte pop duplicates that byte.
// [RULE9] Short packets: read only after full reception.
// [RULE10] Long packets: poll count until two reads agree.
// [RULE11] Read one fewer than count until remainder.
// [RULE12] Four-bit setting picks sixteen shared thresholds.
// [RULE13] Receive 4*(s+1), transmit 61-4*s.
// [RULE14] Threshold flag high while count at or above.
// [RULE15] Pin code 0x00 receive flag, 0x02 transmit flag.
// [RULE16] Sleep entry empties both buffers.
// [RULE17] Fill counters span 0 through 64, give full/empty.

package rtf_pkg;

  localparam int RTF_DEPTH = 64;
  localparam int RTF_PTR_W = 6;
  localparam int RTF_CNT_W = 7;
  localparam int RTF_DATA_W = 8;
  localparam int RTF_PINS = 3;
  localparam int RTF_SEL_W = 6;

  // Register byte addresses
  localparam logic [7:0] RTF_OFS_CTRL = 8'h00;
  localparam logic [7:0] RTF_OFS_THRSEL = 8'h04;
  localparam logic [7:0] RTF_OFS_PINSEL = 8'h08;
  localparam logic [7:0] RTF_OFS_RXFILL = 8'h0c;
  localparam logic [7:0] RTF_OFS_TXFILL = 8'h10;
  localparam logic [7:0] RTF_OFS_IRQSTAT = 8'h14;
  localparam logic [7:0] RTF_OFS_IRQMASK = 8'h18;
  localparam logic [7:0] RTF_OFS_TXDATA = 8'h1c;
  localparam logic [7:0] RTF_OFS_RXDATA = 8'h20;
  localparam logic [7:0] RTF_OFS_HDRSTAT = 8'h24;
  localparam logic [7:0] RTF_OFS_THRFLAG = 8'h28;

  // Control register bits (write one, self clearing)
  localparam int RTF_CTRL_FLUSH_RX = 0;
  localparam int RTF_CTRL_FLUSH_TX = 1;

  // Interrupt status and mask bits
  localparam int RTF_IRQ_W = 4;
  localparam int RTF_IRQ_RX_OVF = 0;
  localparam int RTF_IRQ_TX_UNF = 1;
  localparam int RTF_IRQ_TX_OVF = 2;
  localparam int RTF_IRQ_RX_UNF = 3;

  // Pin select fields, one byte lane each
  localparam int RTF_PINSEL_POS0 = 0;
  localparam int RTF_PINSEL_POS1 = 8;
  localparam int RTF_PINSEL_POS2 = 16;

  // Pin select codes
  localparam logic [5:0] RTF_SEL_RX_THR = 6'h00;
  localparam logic [5:0] RTF_SEL_TX_THR = 6'h02;

  // Reset values
  localparam logic [3:0] RTF_THRSEL_RST = 4'h7;
  localparam logic [5:0] RTF_PINSEL0_RST = 6'h00;
  localparam logic [5:0] RTF_PINSEL1_RST = 6'h02;
  localparam logic [5:0] RTF_PINSEL2_RST = 6'h3f;
  localparam logic [3:0] RTF_IRQMASK_RST = 4'h0;

  // Header status: bit 7 marks a write access
  localparam int RTF_HDR_DIR_POS = 7;

  // Threshold arithmetic
  localparam logic [6:0] RTF_RX_THR_STEP = 7'h04;
  localparam logic [6:0] RTF_TX_THR_BASE = 7'h3d;

  function automatic logic [6:0] rtf_rx_threshold(input logic [3:0] s);
    rtf_rx_threshold = {1'b0, s, 2'b00} + RTF_RX_THR_STEP;
  endfunction

  function automatic logic [6:0] rtf_tx_threshold(input logic [3:0] s);
    rtf_tx_threshold = RTF_TX_THR_BASE - {1'b0, s, 2'b00};
  endfunction

endpackage

// ### src/rtf_byte_fifo.sv
// Purpose: One 64-entry byte buffer with fill count and error pulses.
// Assumes: Push and pop come from logic on core_clk.
// Notes:   Head data is combinational from the storage array.

`timescale 1ns/100ps
`default_nettype none

module rtf_byte_fifo
  import rtf_pkg::*;
#(
  parameter bit DUP_ON_RACE = 1'b0
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic flush,
  input wire logic push,
  input wire logic [7:0] push_data,
  input wire logic pop,
  output logic [7:0] head_data,
  output logic [6:0] fill_count,
  output logic overflow,
  output logic underflow
);

  logic [7:0] mem [RTF_DEPTH];
  logic [5:0] wr_ptr_reg;
  logic [5:0] rd_ptr_reg;
  logic [6:0] count_reg;
  logic full;
  logic empty;
  logic do_push;
  logic do_pop;
  logic race;

  assign full = (count_reg == 7'(RTF_DEPTH)); // RULE17
  assign empty = (count_reg == 7'h00); // RULE17
  assign do_push = push && !full;
  assign do_pop = pop && !empty;
  assign overflow = push && full && !flush; // RULE3
  assign underflow = pop && empty && !flush; // RULE3
  // Push racing the pop of the final byte leaves the read pointer behind
  assign race = DUP_ON_RACE && do_push && do_pop && (count_reg == 7'h01); // RULE8
  assign head_data = mem[rd_ptr_reg];
  assign fill_count = count_reg;

  always_ff @(posedge core_clk) begin
    if (do_push && !flush) begin
      mem[wr_ptr_reg] <= push_data; // RULE1
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr_reg <= 6'h00;
      rd_ptr_reg <= 6'h00;
      count_reg <= 7'h00;
    end else if (flush) begin
      wr_ptr_reg <= 6'h00; // RULE16
      rd_ptr_reg <= 6'h00;
      count_reg <= 7'h00;
    end else begin
      if (do_push) begin
        wr_ptr_reg <= wr_ptr_reg + 6'h01;
      end
      if (do_pop && !race) begin
        rd_ptr_reg <= rd_ptr_reg + 6'h01;
      end
      if (race) begin
        count_reg <= count_reg + 7'h01; // RULE8
      end else if (do_push && !do_pop) begin
        count_reg <= count_reg + 7'h01;
      end else if (do_pop && !do_push) begin
        count_reg <= count_reg - 7'h01;
      end
    end
  end

endmodule

`default_nettype wire

// ### src/rtf_data_fifo.sv
// Purpose: Receive and transmit data buffers with Avalon-MM registers,
//          threshold flags, output pin routing and interrupt.
// Assumes: Receiver, transmitter and sleep entry run on core_clk.
// Notes:   Every request answers with waitrequest low one cycle later.
//          Flush on sleep or control write wins over push and pop.
//
// Chosen here: the register addresses and register access over Avalon-MM.

`timescale 1ns/100ps
`default_nettype none

module rtf_data_fifo
  import rtf_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic rx_push,
  input wire logic [7:0] rx_push_data,
  input wire logic tx_pop,
  output logic [7:0] tx_pop_data,
  input wire logic sleep_enter,
  output logic [2:0] general_output_pin,
  output logic rx_threshold_flag,
  output logic tx_threshold_flag,
  output logic [7:0] header_status,
  output logic irq
);

  logic req;
  logic capture;
  logic accept;
  logic wr_acc;
  logic rd_acc;
  logic rx_pop_host;
  logic tx_push_host;
  logic flush_rx;
  logic flush_tx;
  logic [7:0] rx_head;
  logic [7:0] tx_head;
  logic [6:0] rx_fill_count;
  logic [6:0] tx_fill_count;
  logic rx_ovf;
  logic rx_unf;
  logic tx_ovf;
  logic tx_unf;
  logic [3:0] fifo_threshold_select;
  logic [5:0] output_pin_select [RTF_PINS];
  logic [3:0] irq_mask_reg;
  logic [3:0] irq_status_reg;
  logic [3:0] irq_status_next;
  logic [3:0] irq_events;
  logic [3:0] irq_clear_reg;
  logic [31:0] read_mux;
  logic rx_thr_level;
  logic tx_thr_level;
  logic ctrl_wr;
  logic irq_read_clear;
  logic irq_read_capture;

  // Pin routing of the threshold flags
  function automatic logic pin_source(input logic [5:0] sel,
                                      input logic rx_flag,
                                      input logic tx_flag);
    logic val;
    val = 1'b0;
    unique case (sel)
      RTF_SEL_RX_THR: begin
        val = rx_flag; // RULE15
      end
      RTF_SEL_TX_THR: begin
        val = tx_flag; // RULE15
      end
      default: begin
        val = 1'b0;
      end
    endcase
    pin_source = val;
  endfunction

  // Write to one register with its low byte lane enabled
  function automatic logic wr_hit(input logic acc,
                                  input logic [7:0] addr,
                                  input logic [7:0] ofs,
                                  input logic be0);
    wr_hit = acc && (addr == ofs) && be0;
  endfunction

  // Bus handshake terms
  assign req = avs_read || avs_write;
  assign capture = req && avs_waitrequest;
  assign accept = req && !avs_waitrequest;
  assign wr_acc = accept && avs_write;
  assign rd_acc = accept && avs_read;

  // Host only drains receive and only fills transmit
  assign rx_pop_host = rd_acc && (avs_address == RTF_OFS_RXDATA); // RULE2
  assign tx_push_host = wr_hit(wr_acc, avs_address, RTF_OFS_TXDATA,
                               avs_byteenable[0]); // RULE2

  // Sleep entry or a control write empties the buffers
  assign ctrl_wr = wr_hit(wr_acc, avs_address, RTF_OFS_CTRL,
                          avs_byteenable[0]);
  assign flush_rx = sleep_enter ||
                    (ctrl_wr && avs_writedata[RTF_CTRL_FLUSH_RX]); // RULE16
  assign flush_tx = sleep_enter ||
                    (ctrl_wr && avs_writedata[RTF_CTRL_FLUSH_TX]); // RULE16

  rtf_byte_fifo #(
    .DUP_ON_RACE(1'b1)
  ) u_rx_fifo (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .flush(flush_rx),
    .push(rx_push),
    .push_data(rx_push_data),
    .pop(rx_pop_host),
    .head_data(rx_head),
    .fill_count(rx_fill_count),
    .overflow(rx_ovf),
    .underflow(rx_unf)
  );

  rtf_byte_fifo #(
    .DUP_ON_RACE(1'b0)
  ) u_tx_fifo (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .flush(flush_tx),
    .push(tx_push_host),
    .push_data(avs_writedata[7:0]),
    .pop(tx_pop),
    .head_data(tx_head),
    .fill_count(tx_fill_count),
    .overflow(tx_ovf),
    .underflow(tx_unf)
  );

  // Threshold comparison, shared setting for both buffers
  assign rx_thr_level = (rx_fill_count >=
                         rtf_rx_threshold(fifo_threshold_select)); // RULE13
  assign tx_thr_level = (tx_fill_count >=
                         rtf_tx_threshold(fifo_threshold_select)); // RULE13

  // Interrupt events and read-to-clear
  assign irq_events[RTF_IRQ_RX_OVF] = rx_ovf; // RULE3
  assign irq_events[RTF_IRQ_TX_UNF] = tx_unf; // RULE3
  assign irq_events[RTF_IRQ_TX_OVF] = tx_ovf;
  assign irq_events[RTF_IRQ_RX_UNF] = rx_unf;
  assign irq_read_clear = rd_acc && (avs_address == RTF_OFS_IRQSTAT);
  assign irq_read_capture = capture && avs_read &&
                            (avs_address == RTF_OFS_IRQSTAT);

  always_comb begin
    irq_status_next = irq_status_reg;
    if (irq_read_clear) begin
      irq_status_next = irq_status_reg & ~irq_clear_reg;
    end
    irq_status_next = irq_status_next | irq_events;
  end

  // Read data selection
  always_comb begin
    read_mux = 32'h0000_0000;
    unique case (avs_address)
      RTF_OFS_THRSEL: begin
        read_mux[3:0] = fifo_threshold_select;
      end
      RTF_OFS_PINSEL: begin
        read_mux[RTF_PINSEL_POS0 +: RTF_SEL_W] = output_pin_select[0];
        read_mux[RTF_PINSEL_POS1 +: RTF_SEL_W] = output_pin_select[1];
        read_mux[RTF_PINSEL_POS2 +: RTF_SEL_W] = output_pin_select[2];
      end
      RTF_OFS_RXFILL: begin
        read_mux[6:0] = rx_fill_count; // RULE7
      end
      RTF_OFS_TXFILL: begin
        read_mux[6:0] = tx_fill_count; // RULE7
      end
      RTF_OFS_IRQSTAT: begin
        read_mux[3:0] = irq_status_reg;
      end
      RTF_OFS_IRQMASK: begin
        read_mux[3:0] = irq_mask_reg;
      end
      RTF_OFS_RXDATA: begin
        read_mux[7:0] = rx_head;
      end
      RTF_OFS_HDRSTAT: begin
        read_mux[7:0] = header_status;
      end
      RTF_OFS_THRFLAG: begin
        read_mux[1:0] = {tx_threshold_flag, rx_threshold_flag};
      end
      default: begin
        read_mux = 32'h0000_0000;
      end
    endcase
  end

  // Waitrequest: low for exactly one cycle after a request is seen
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
    end else if (capture) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // Read data captured one edge before the accepting edge
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (capture && avs_read) begin
      avs_readdata <= read_mux;
    end
  end

  // Only the status bits actually returned are cleared
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_clear_reg <= 4'h0;
    end else if (irq_read_capture) begin
      irq_clear_reg <= irq_status_reg;
    end else if (accept) begin
      irq_clear_reg <= 4'h0;
    end
  end

  // Header status byte: receive fill on reads, transmit fill on writes
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      header_status <= 8'h00;
    end else if (capture) begin
      if (avs_write) begin
        header_status <= {1'b1, tx_fill_count}; // RULE6
      end else begin
        header_status <= {1'b0, rx_fill_count}; // RULE6
      end
    end
  end

  // Threshold setting
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fifo_threshold_select <= RTF_THRSEL_RST;
    end else if (wr_hit(wr_acc, avs_address, RTF_OFS_THRSEL,
                        avs_byteenable[0])) begin
      fifo_threshold_select <= avs_writedata[3:0]; // RULE12
    end
  end

  // Output pin selection, one byte lane per pin
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      output_pin_select[0] <= RTF_PINSEL0_RST;
      output_pin_select[1] <= RTF_PINSEL1_RST;
      output_pin_select[2] <= RTF_PINSEL2_RST;
    end else if (wr_acc && (avs_address == RTF_OFS_PINSEL)) begin
      if (avs_byteenable[0]) begin
        output_pin_select[0] <=
          avs_writedata[RTF_PINSEL_POS0 +: RTF_SEL_W];
      end
      if (avs_byteenable[1]) begin
        output_pin_select[1] <=
          avs_writedata[RTF_PINSEL_POS1 +: RTF_SEL_W];
      end
      if (avs_byteenable[2]) begin
        output_pin_select[2] <=
          avs_writedata[RTF_PINSEL_POS2 +: RTF_SEL_W];
      end
    end
  end

  // Interrupt mask
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_mask_reg <= RTF_IRQMASK_RST;
    end else if (wr_hit(wr_acc, avs_address, RTF_OFS_IRQMASK,
                        avs_byteenable[0])) begin
      irq_mask_reg <= avs_writedata[3:0];
    end
  end

  // Sticky status, set wins over clear
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_status_reg <= 4'h0;
    end else begin
      irq_status_reg <= irq_status_next;
    end
  end

  // Interrupt output
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_next & irq_mask_reg);
    end
  end

  // Threshold flags follow the fill counts
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_threshold_flag <= 1'b0;
      tx_threshold_flag <= 1'b0;
    end else begin
      rx_threshold_flag <= rx_thr_level; // RULE14
      tx_threshold_flag <= tx_thr_level; // RULE14
    end
  end

  // General-purpose output pins
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      general_output_pin <= 3'h0;
    end else begin
      for (int i = 0; i < RTF_PINS; i++) begin
        general_output_pin[i] <= pin_source(output_pin_select[i],
                                            rx_thr_level,
                                            tx_thr_level); // RULE14
      end
    end
  end

  // Transmit data handed to the transmitter on each pop from a non-empty buffer
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_pop_data <= 8'h00;
    end else if (tx_pop && !flush_tx &&
                 (tx_fill_count != 7'h00)) begin
      tx_pop_data <= tx_head;
    end
  end

endmodule

`default_nettype wire

// ### tb/rtf_radio_model.sv
// Purpose: Radio side of the buffers: receiver pushes, transmitter pops.
// Assumes: One byte per cycle, counts loaded by a go pulse.
// Notes: Received bytes count up from 8'h80.
`timescale 1ns/100ps
`default_nettype none
module rtf_radio_model (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic push_go,
  input wire logic pop_go,
  input wire logic [6:0] cnt,
  output logic rx_push,
  output logic [7:0] rx_push_data,
  output logic tx_pop,
  output logic busy
);
  logic [6:0] push_left;
  logic [6:0] pop_left;
  assign rx_push = push_left != 7'h00;
  assign tx_pop = pop_left != 7'h00;
  assign busy = rx_push | tx_pop;
  // Back to back pushes, also into a full buffer
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      push_left <= 7'h00;
      rx_push_data <= 8'h80;
    end else if (push_go) begin
      push_left <= cnt;
    end else if (rx_push) begin
      push_left <= push_left - 7'h01;
      rx_push_data <= rx_push_data + 8'h01;
    end
  end
  // Back to back pops, also from an empty buffer
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pop_left <= 7'h00;
    end else if (pop_go) begin
      pop_left <= cnt;
    end else if (tx_pop) begin
      pop_left <= pop_left - 7'h01;
    end
  end
endmodule
`default_nettype wire

// ### tb/rtf_data_fifo_chk.sv
// Purpose: Port checks on bus handshake, header status, transmit data.
// Assumes: Single clock, reset active high.
// Notes: Bound to every data buffer block.
`timescale 1ns/100ps
`default_nettype none
module rtf_data_fifo_chk (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  input wire logic [7:0] header_status,
  input wire logic tx_pop,
  input wire logic [7:0] tx_pop_data
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence capture;
    (avs_read | avs_write) && avs_waitrequest;
  endsequence
  sequence answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  AST_WAIT_ONE: assert property (capture |=> answer)
    else $error("answer not one cycle after capture");
  AST_WAIT_IDLE: assert property (
    !(avs_read | avs_write) && avs_waitrequest |=> avs_waitrequest)
    else $error("answer without request");
  AST_FELL_CAUSE: assert property (
    $fell(avs_waitrequest) |-> $past(avs_read | avs_write))
    else $error("waitrequest fell with no request");
  AST_HDR_DIR: assert property (
    capture |=> header_status[7] == $past(avs_write))
    else $error("header direction bit wrong");
  AST_HDR_STABLE: assert property (
    !((avs_read | avs_write) && avs_waitrequest) |=>
      $stable(header_status))
    else $error("header status changed without request");
  AST_HDR_RANGE: assert property (header_status[6:0] <= 7'h40)
    else $error("header fill above 64");
  AST_RDATA_HOLD: assert property (
    !(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("read data changed without read");
  AST_TXDATA_HOLD: assert property (!tx_pop |=> $stable(tx_pop_data))
    else $error("transmit data changed without pop");
endmodule
bind rtf_data_fifo rtf_data_fifo_chk i_chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .avs_readdata(avs_readdata), .header_status(header_status),
  .tx_pop(tx_pop), .tx_pop_data(tx_pop_data));
`default_nettype wire

// ### tb/rtf_data_fifo_tb.sv
// Purpose: Register level test of the receive and transmit buffers.
// Assumes: Avalon answer comes within 20 cycles.
// Notes: Flag checks wait three cycles after a setting change.
`timescale 1ns/100ps
`default_nettype none
module rtf_data_fifo_tb;
  import rtf_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic rx_push, tx_pop, busy, irq, rx_thr, tx_thr;
  logic [7:0] rx_push_data, tx_pop_data, header_status;
  logic [2:0] pins;
  logic sleep_enter = 1'b0;
  logic push_go = 1'b0;
  logic pop_go = 1'b0;
  logic [6:0] cnt = 7'h00;
  logic [31:0] q;
  int fails = 0;
  int checks = 0;
  int i;
  initial forever #25 core_clk = ~core_clk;
  rtf_data_fifo i_dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rx_push(rx_push),
    .rx_push_data(rx_push_data), .tx_pop(tx_pop),
    .tx_pop_data(tx_pop_data), .sleep_enter(sleep_enter),
    .general_output_pin(pins), .rx_threshold_flag(rx_thr),
    .tx_threshold_flag(tx_thr), .header_status(header_status),
    .irq(irq));
  rtf_radio_model i_radio (.core_clk(core_clk), .sys_rst(sys_rst),
    .push_go(push_go), .pop_go(pop_go), .cnt(cnt), .rx_push(rx_push),
    .rx_push_data(rx_push_data), .tx_pop(tx_pop), .busy(busy));
  task automatic stop_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic acc(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    for (k = 0; k < 20; k++) begin
      @(posedge core_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (k == 20) begin
      fails++;
      stop_test();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    acc(a, 1'b0, 32'h0);
    check(nm, q, e);
  endtask
  task automatic radio(input logic push, input logic [6:0] c);
    int k;
    @(posedge core_clk);
    cnt <= c;
    push_go <= push;
    pop_go <= !push;
    @(posedge core_clk);
    push_go <= 1'b0;
    pop_go <= 1'b0;
    @(posedge core_clk);
    for (k = 0; k < 200 && busy !== 1'b0; k++) @(posedge core_clk);
    if (k == 200) begin
      fails++;
      stop_test();
    end
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    rc("thrsel", RTF_OFS_THRSEL, 32'h7);
    rc("pinsel", RTF_OFS_PINSEL, 32'h003f0200);
    rc("mask", RTF_OFS_IRQMASK, 32'h0);
    rc("rxfill", RTF_OFS_RXFILL, 32'h0);
    rc("unmapped", 8'h3c, 32'h0);
    for (i = 0; i < 33; i++) acc(RTF_OFS_TXDATA, 1'b1, i);
    check("hdr", header_status, 32'ha0);
    radio(1'b1, 7'd32);
    rc("rxfill", RTF_OFS_RXFILL, 32'd32);
    check("hdr", header_status, 32'h20);
    rc("txfill", RTF_OFS_TXFILL, 32'd33);
    for (i = 0; i < 16; i++) begin
      acc(RTF_OFS_THRSEL, 1'b1, i);
      repeat (3) @(posedge core_clk);
      check("rxflag", rx_thr, 32 >= 4 * (i + 1));
      check("txflag", tx_thr, 33 >= 61 - 4 * i);
      check("pins", pins, {33 >= 61 - 4 * i, 32 >= 4 * (i + 1)});
      rc("thrflag", RTF_OFS_THRFLAG,
         {33 >= 61 - 4 * i, 32 >= 4 * (i + 1)});
    end
    for (i = 33; i < 65; i++) acc(RTF_OFS_TXDATA, 1'b1, i);
    repeat (2) @(posedge core_clk);
    check("irq", irq, 32'h0);
    rc("txfill", RTF_OFS_TXFILL, 32'd64);
    acc(RTF_OFS_IRQMASK, 1'b1, 32'hf);
    repeat (2) @(posedge core_clk);
    check("irq", irq, 32'h1);
    rc("irqstat", RTF_OFS_IRQSTAT, 32'h4);
    repeat (2) @(posedge core_clk);
    check("irq", irq, 32'h0);
    radio(1'b1, 7'd33);
    rc("rxfill", RTF_OFS_RXFILL, 32'd64);
    rc("irqstat", RTF_OFS_IRQSTAT, 32'h1);
    rc("rxdata", RTF_OFS_RXDATA, 32'h80);
    rc("rxfill", RTF_OFS_RXFILL, 32'd63);
    radio(1'b0, 7'd65);
    check("txdata", tx_pop_data, 32'h3f);
    rc("irqstat", RTF_OFS_IRQSTAT, 32'h2);
    acc(RTF_OFS_TXDATA, 1'b1, 32'h55);
    @(posedge core_clk);
    sleep_enter <= 1'b1;
    @(posedge core_clk);
    sleep_enter <= 1'b0;
    rc("rxfill", RTF_OFS_RXFILL, 32'h0);
    rc("txfill", RTF_OFS_TXFILL, 32'h0);
    radio(1'b1, 7'd1);
    fork
      rc("rxdata", RTF_OFS_RXDATA, 32'hc1);
      radio(1'b1, 7'd1);
    join
    rc("rxfill", RTF_OFS_RXFILL, 32'd2);
    rc("rxfill", RTF_OFS_RXFILL, 32'd2);
    rc("rxdata", RTF_OFS_RXDATA, 32'hc1);
    rc("rxdata", RTF_OFS_RXDATA, 32'hc2);
    acc(RTF_OFS_TXDATA, 1'b1, 32'h11);
    acc(RTF_OFS_CTRL, 1'b1, 32'h2);
    rc("txfill", RTF_OFS_TXFILL, 32'h0);
    stop_test();
  end
endmodule
`default_nettype wire
